// ==== design/sys_status_pkg.sv ====
package sys_status_pkg;
   // timing, clock at 10 MHz
   localparam int CLK_NS = 100;
   localparam int PFAIL_US = 16600;
   localparam int MAINS_CYC_US = 33200;
   localparam int SHUT_US = 100000;
   localparam int SEP_US = 50000;
   // least times round up to whole cycles
   localparam int PFAIL_CYC = (PFAIL_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SHUT_CYC = (SHUT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SEP_CYC = (SEP_US * 1000 + CLK_NS - 1) / CLK_NS;
   // longest time for auto clear rounds down
   localparam int MAINS_CYC = (MAINS_CYC_US * 1000) / CLK_NS;
   localparam int CNT_W = 24;
   // apb map: word k holds bits 32k .. 32k+31
   localparam int ADDR_W = 12;
   localparam int NUM_WORDS = 7;
   localparam int IMG_W = 224;
   localparam int IDX_W = 3;
   // processor units behind the scanner
   localparam int UNITS = 16;
   localparam int UNIT_ERR_W = 5;
   localparam int SCAN_W = 4;
   localparam int NUM_PP = 10;
   localparam int NUM_CH = 12;
   localparam int SUM_BITS = 40;
   localparam logic [5:0] OP_STOP_LO = 6'h00;
   localparam logic [5:0] OP_STOP_HI = 6'h3f;
   // bit positions in the wide register
   localparam int B_CM_RANK2 = 3;
   localparam int B_PPU_ERR = 4;
   localparam int B_RX_IC = 6;
   localparam int B_TX_IC = 7;
   localparam int B_SUM2 = 10;
   localparam int B_LCM_RANK2 = 11;
   localparam int B_PP_PAR = 14;
   localparam int B_CH_PAR = 24;
   localparam int B_PFAIL = 36;
   localparam int B_SHUT = 37;
   localparam int B_SYND = 40;
   localparam int B_ADDR_HI = 48;
   localparam int B_ADDR_LO = 50;
   localparam int B_SCAN = 72;
   localparam int B_UNIT_ERR = 132;
   localparam int B_ADDR_MID = 156;
   localparam int B_CM_CLR = 168;
   localparam int B_LCM_PAR = 171;
   localparam int B_CM_PAR = 174;
   localparam int B_LCM_CLR = 176;
   localparam int B_CM_DBL = 183;
   localparam int B_DEGRADE = 192;
   localparam int B_LCM_DBL = 196;
   localparam int B_RECONF = 197;
   // synchronised pin inputs
   localparam int SY_MAINS = 0;
   localparam int SY_ENV_ABN = 1;
   localparam int SY_ENV_EMERG = 2;
   localparam int SY_ENV_CTL = 3;
   localparam int SY_SECOND = 4;
   localparam int SY_DEG = 5;
   localparam int SY_CHDIS = 9;
   localparam int SYNC_W = 21;
endpackage

// ==== design/system_error_status_register.sv ====
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module system_error_status_register #(
   parameter int PFAIL_CYCLES = sys_status_pkg::PFAIL_CYC,
   parameter int SHUT_CYCLES = sys_status_pkg::SHUT_CYC,
   parameter int MAINS_CYCLES = sys_status_pkg::MAINS_CYC,
   parameter int SEP_CYCLES = sys_status_pkg::SEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [sys_status_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cm_err_valid,
   input wire logic cm_err_double,
   input wire logic [7:0] cm_syndrome,
   input wire logic [17:0] cm_err_addr,
   input wire logic lcm_err_valid,
   input wire logic lcm_err_double,
   input wire logic ppu_parity_err,
   input wire logic ppu_cm_read_err,
   input wire logic ppu_opcode_valid,
   input wire logic [5:0] ppu_opcode,
   input wire logic [79:0] ppu_unit_err,
   input wire logic rx_ichassis_err,
   input wire logic tx_ichassis_err,
   input wire logic [39:0] second_chassis_status,
   input wire logic [9:0] pp_mem_parity_err,
   input wire logic [11:0] chan_parity_err,
   input wire logic [11:0] chan_check_disable,
   input wire logic mains_ok,
   input wire logic env_abnormal,
   input wire logic env_emergency,
   input wire logic env_controlled,
   input wire logic [3:0] lcm_degrade,
   input wire logic [4:0] ppm_reconfig,
   output logic [3:0] scanner_select
);
   localparam int CW = sys_status_pkg::CNT_W;
   localparam int SW = sys_status_pkg::SYNC_W;
   localparam int IW = sys_status_pkg::IMG_W;
   localparam logic [CW-1:0] PF_N = CW'(PFAIL_CYCLES);
   localparam logic [CW-1:0] SH_N = CW'(SHUT_CYCLES);
   localparam logic [CW-1:0] MC_N = CW'(MAINS_CYCLES);

   // counters only fit 24 bits; shutdown must trail failure by the gap
   if (SHUT_CYCLES >= (1 << CW) || MAINS_CYCLES >= (1 << CW) || PFAIL_CYCLES < 1
       || SHUT_CYCLES - PFAIL_CYCLES < SEP_CYCLES) begin : g_bad_timing
      $error("timing parameters out of range");
   end

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [3:0] scan;
      logic cm_clr;
      logic lcm_par;
      logic cm_par;
      logic lcm_clr;
      logic cm_rank2;
      logic ppu_err;
      logic rx_ic;
      logic tx_ic;
      logic lcm_rank2;
      logic [9:0] pp_par;
      logic [11:0] ch_par;
      logic pfail;
      logic shut;
      logic emerg;
      logic [7:0] synd;
      logic [17:0] addr;
      logic cm_dbl;
      logic lcm_dbl;
      logic [4:0] reconf;
      logic reconf_taken;
      logic [CW-1:0] out_cnt;
      logic [CW-1:0] pf_age;
      logic [CW-1:0] si_age;
      logic [SW-1:0] s1;
      logic [SW-1:0] s2;
      logic [SW-1:0] s3;
      logic [SW-1:0] filt;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [SW-1:0] pins;
   logic [IW-1:0] img;
   logic [sys_status_pkg::IDX_W-1:0] idx;
   logic mapped;
   logic wr_en;
   logic [IW-1:0] wr_bits;
   logic env_any_q;

   // the word an apb write lands in, moved to its place in the image
   function automatic logic [IW-1:0] place(input logic [sys_status_pkg::IDX_W-1:0] i,
                                           input logic [31:0] d);
      logic [IW-1:0] v;
      v = '0;
      v[32 * i +: 32] = d;
      return v;
   endfunction

   // the register as software sees it; gaps stay zero
   function automatic logic [IW-1:0] image(input state_t s, input logic [79:0] ue,
                                           input logic [SW-1:0] f);
      logic [IW-1:0] v;
      v = '0;
      v[sys_status_pkg::B_CM_RANK2] = s.cm_rank2;
      v[sys_status_pkg::B_PPU_ERR] = s.ppu_err;
      v[sys_status_pkg::B_RX_IC] = s.rx_ic;
      v[sys_status_pkg::B_TX_IC] = s.tx_ic;
      v[sys_status_pkg::B_SUM2] = f[sys_status_pkg::SY_SECOND];
      v[sys_status_pkg::B_LCM_RANK2] = s.lcm_rank2;
      v[sys_status_pkg::B_PP_PAR +: 10] = s.pp_par;
      v[sys_status_pkg::B_CH_PAR +: 12] = s.ch_par;
      v[sys_status_pkg::B_PFAIL] = s.pfail;
      v[sys_status_pkg::B_SHUT] = s.shut;
      v[sys_status_pkg::B_SYND +: 8] = s.synd;
      v[sys_status_pkg::B_ADDR_HI +: 2] = s.addr[17:16];
      v[sys_status_pkg::B_ADDR_LO +: 4] = s.addr[3:0];
      v[sys_status_pkg::B_ADDR_MID +: 12] = s.addr[15:4];
      v[sys_status_pkg::B_SCAN +: 4] = s.scan;
      // selected unit's own error bits, live from that unit
      v[sys_status_pkg::B_UNIT_ERR +: 5] = ue[s.scan * 5 +: 5];
      v[sys_status_pkg::B_CM_CLR] = s.cm_clr;
      v[sys_status_pkg::B_LCM_PAR] = s.lcm_par;
      v[sys_status_pkg::B_CM_PAR] = s.cm_par;
      v[sys_status_pkg::B_LCM_CLR] = s.lcm_clr;
      v[sys_status_pkg::B_CM_DBL] = s.cm_dbl;
      v[sys_status_pkg::B_DEGRADE +: 4] = f[sys_status_pkg::SY_DEG +: 4];
      v[sys_status_pkg::B_LCM_DBL] = s.lcm_dbl;
      v[sys_status_pkg::B_RECONF +: 5] = s.reconf;
      return v;
   endfunction

   assign env_any_q = st_reg.filt[sys_status_pkg::SY_ENV_ABN] ||
                      st_reg.filt[sys_status_pkg::SY_ENV_EMERG] ||
                      st_reg.filt[sys_status_pkg::SY_ENV_CTL];
   assign pins = {chan_check_disable, lcm_degrade, |second_chassis_status,
                  env_controlled, env_emergency, env_abnormal, mains_ok};
   assign img = image(st_reg, ppu_unit_err, st_reg.filt);
   assign idx = paddr[2 +: sys_status_pkg::IDX_W];
   assign mapped = paddr[1:0] == 2'h0 &&
                   paddr < sys_status_pkg::ADDR_W'(sys_status_pkg::NUM_WORDS * 4);
   assign wr_en = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
   // write-one clears for the flag bits, plain store for control bits; syndrome, address and double bits clear only via 168 and 176
   assign wr_bits = wr_en ? place(idx, pwdata) : '0;

   always_comb begin
      logic mains_off;
      logic env_any;
      logic si_cond;
      logic stop_op;
      mains_off = 1'b0;
      env_any = 1'b0;
      si_cond = 1'b0;
      stop_op = 1'b0;
      st_next = st_reg;
      // three-stage pin sync; a change counts when stages two and three agree
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < SW; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.filt[i] = st_reg.s3[i];
         end
      end

      // apb slave: one wait state, answer on the second access cycle
      if (psel && penable && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.pslverr = !mapped;
         st_next.prdata = (mapped && !pwrite) ? img[32 * idx +: 32] : 32'h0000_0000;
      end else begin
         st_next.pready = 1'b0;
         st_next.pslverr = 1'b0;
      end

      // control bits; reserved and status-only positions ignore stored writes
      if (wr_en && idx == 3'(sys_status_pkg::B_SCAN / 32)) begin
         st_next.scan = pwdata[sys_status_pkg::B_SCAN % 32 +: 4];
      end
      if (wr_en && idx == 3'(sys_status_pkg::B_CM_CLR / 32)) begin
         st_next.cm_clr = pwdata[sys_status_pkg::B_CM_CLR % 32];
         st_next.lcm_par = pwdata[sys_status_pkg::B_LCM_PAR % 32];
         st_next.cm_par = pwdata[sys_status_pkg::B_CM_PAR % 32];
         st_next.lcm_clr = pwdata[sys_status_pkg::B_LCM_CLR % 32];
      end

      // straps caught once after reset release
      if (!st_reg.reconf_taken) begin
         st_next.reconf = ppm_reconfig;
         st_next.reconf_taken = 1'b1;
      end

      // central memory: clear holds while 168 is set; a new error still wins
      if (st_reg.cm_clr) begin
         st_next.synd = '0;
         st_next.addr = '0;
         st_next.cm_dbl = 1'b0;
      end
      if (wr_bits[sys_status_pkg::B_CM_RANK2]) begin
         st_next.cm_rank2 = 1'b0;
      end
      if (cm_err_valid) begin
         st_next.cm_rank2 = 1'b1;
         // first failing word is held until the clear
         if (st_next.synd == 8'h00) begin
            st_next.synd = cm_syndrome;
            st_next.addr = cm_err_addr;
         end
         if (!st_reg.cm_par && cm_err_double) begin
            st_next.cm_dbl = 1'b1;
         end
      end

      // extended memory, same scheme under 171 and 176
      if (st_reg.lcm_clr) begin
         st_next.lcm_dbl = 1'b0;
      end
      if (wr_bits[sys_status_pkg::B_LCM_RANK2]) begin
         st_next.lcm_rank2 = 1'b0;
      end
      if (lcm_err_valid) begin
         st_next.lcm_rank2 = 1'b1;
         if (!st_reg.lcm_par && lcm_err_double) begin
            st_next.lcm_dbl = 1'b1;
         end
      end

      // processor units
      stop_op = ppu_opcode_valid && (ppu_opcode == sys_status_pkg::OP_STOP_LO ||
                                     ppu_opcode == sys_status_pkg::OP_STOP_HI);
      st_next.ppu_err = (st_reg.ppu_err && !wr_bits[sys_status_pkg::B_PPU_ERR]) ||
                        ppu_parity_err || ppu_cm_read_err || stop_op;
      st_next.rx_ic = (st_reg.rx_ic && !wr_bits[sys_status_pkg::B_RX_IC]) ||
                      rx_ichassis_err;
      st_next.tx_ic = (st_reg.tx_ic && !wr_bits[sys_status_pkg::B_TX_IC]) ||
                      tx_ichassis_err;
      st_next.pp_par = (st_reg.pp_par & ~wr_bits[sys_status_pkg::B_PP_PAR +: 10]) |
                       pp_mem_parity_err;
      st_next.ch_par = (st_reg.ch_par & ~wr_bits[sys_status_pkg::B_CH_PAR +: 12]) |
                       (chan_parity_err &
                        ~st_reg.filt[sys_status_pkg::SY_CHDIS +: 12]);

      // power and environment
      mains_off = !st_reg.filt[sys_status_pkg::SY_MAINS];
      env_any = st_reg.filt[sys_status_pkg::SY_ENV_ABN] ||
                st_reg.filt[sys_status_pkg::SY_ENV_EMERG] ||
                st_reg.filt[sys_status_pkg::SY_ENV_CTL];
      if (!mains_off) begin
         st_next.out_cnt = '0;
      end else if (st_reg.out_cnt != SH_N) begin
         st_next.out_cnt = st_reg.out_cnt + 1'b1;
      end
      st_next.pf_age = !st_reg.pfail ? '0 :
                       (&st_reg.pf_age ? st_reg.pf_age : st_reg.pf_age + 1'b1);
      st_next.si_age = !st_reg.shut ? '0 :
                       (&st_reg.si_age ? st_reg.si_age : st_reg.si_age + 1'b1);

      if (wr_bits[sys_status_pkg::B_PFAIL]) begin
         st_next.pfail = 1'b0;
      end
      // short dips clear themselves; long ones wait for software
      if (st_reg.pfail && !mains_off && st_reg.pf_age < MC_N) begin
         st_next.pfail = 1'b0;
      end
      if ((mains_off && st_reg.out_cnt == PF_N - 1'b1) ||
          st_reg.filt[sys_status_pkg::SY_ENV_CTL]) begin
         st_next.pfail = 1'b1;
      end

      si_cond = (mains_off && st_reg.out_cnt >= SH_N - 1'b1) || env_any;
      if (wr_bits[sys_status_pkg::B_SHUT]) begin
         st_next.shut = 1'b0;
         st_next.emerg = 1'b0;
      end
      // an emergency limit blocks the automatic clear
      if (st_reg.shut && !si_cond && !st_reg.emerg && st_reg.si_age < MC_N) begin
         st_next.shut = 1'b0;
      end
      if (si_cond) begin
         st_next.shut = 1'b1;
      end
      if (st_reg.filt[sys_status_pkg::SY_ENV_EMERG]) begin
         st_next.emerg = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign scanner_select = st_reg.scan;

   a_cm_parity_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && cm_err_valid && st_reg.cm_par && !st_reg.cm_dbl
      |=> st_reg.cm_rank2 && !st_reg.cm_dbl)
      else $error("cm parity error not flagged as single");

   a_cm_double_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && cm_err_valid && !st_reg.cm_par && cm_err_double |=> st_reg.cm_dbl)
      else $error("cm double error not flagged");

   a_cm_clear_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && st_reg.cm_clr && !cm_err_valid
      |=> st_reg.synd == 8'h00 && st_reg.addr == 18'h0_0000 && !st_reg.cm_dbl)
      else $error("cm clear left state behind");

   a_lcm_double_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && lcm_err_valid && !st_reg.lcm_par && lcm_err_double
      |=> st_reg.lcm_rank2 && st_reg.lcm_dbl)
      else $error("extended double error not flagged");

   a_stop_opcode: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ppu_opcode_valid && ppu_opcode == sys_status_pkg::OP_STOP_HI
      |=> st_reg.ppu_err)
      else $error("stop opcode did not flag unit error");

   a_chan_parity: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && chan_parity_err[0] && !st_reg.filt[sys_status_pkg::SY_CHDIS] |=> st_reg.ch_par[0])
      else $error("channel parity error lost");

   a_pfail_time: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !st_reg.filt[sys_status_pkg::SY_MAINS] && st_reg.out_cnt == PF_N - 1'b1
      |=> st_reg.pfail)
      else $error("power failure not set after half cycle");

   a_shut_lead: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(st_reg.shut) && $past(!env_any_q)
      |-> st_reg.pfail && st_reg.pf_age >= CW'(SEP_CYCLES))
      else $error("shutdown set without power failure lead");

   a_summary_or: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && |second_chassis_status) [*3] ##1 ce |-> ##1 img[sys_status_pkg::B_SUM2])
      else $error("second chassis summary not set");

   a_unused_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      img[2:0] == 3'h0 && img[5] == 1'b0 && img[9:8] == 2'h0 && img[203:202] == 2'h0)
      else $error("unused bit reads non-zero");
endmodule // system_error_status_register

// ==== bench/tb_system_error_status_register.sv ====
`timescale 1ns/1ps
module tb_system_error_status_register;
   // short counts keep the run brief; expectations follow these values
   localparam int PF = 20;
   localparam int SH = 100;
   localparam int MC = 40;
   localparam int SP = 50;
   localparam logic [31:0] zero = 32'h0000_0000;
   logic pclk, presetn, ce, psel, penable, pwrite, rerr;
   logic [sys_status_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, cm_err_double, lcm_err_double, mains_ok;
   logic [7:0] cm_syndrome;
   logic [17:0] cm_err_addr;
   logic [5:0] ppu_opcode;
   logic [79:0] ppu_unit_err;
   logic [39:0] second_chassis_status;
   logic [11:0] chan_check_disable;
   logic [3:0] lcm_degrade, scanner_select;
   logic [4:0] ppm_reconfig;
   logic [2:0] env;
   // event pulses: cm, lcm, par, read, opcode, rx, tx, pp[9:0], chan[11:0]
   logic [28:0] ev;
   int n_fail, samples_checked, now;

   system_error_status_register #(.PFAIL_CYCLES(PF), .SHUT_CYCLES(SH), .MAINS_CYCLES(MC),
      .SEP_CYCLES(SP)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cm_err_valid(ev[0]),
      .cm_err_double(cm_err_double), .cm_syndrome(cm_syndrome), .cm_err_addr(cm_err_addr),
      .lcm_err_valid(ev[1]), .lcm_err_double(lcm_err_double), .ppu_parity_err(ev[2]),
      .ppu_cm_read_err(ev[3]), .ppu_opcode_valid(ev[4]), .ppu_opcode(ppu_opcode),
      .ppu_unit_err(ppu_unit_err), .rx_ichassis_err(ev[5]), .tx_ichassis_err(ev[6]),
      .second_chassis_status(second_chassis_status), .pp_mem_parity_err(ev[16:7]),
      .chan_parity_err(ev[28:17]), .chan_check_disable(chan_check_disable),
      .mains_ok(mains_ok), .env_abnormal(env[0]), .env_emergency(env[1]),
      .env_controlled(env[2]), .lcm_degrade(lcm_degrade), .ppm_reconfig(ppm_reconfig),
      .scanner_select(scanner_select));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) now <= now + 1;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         test_done();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input int k, input logic [31:0] exp);
      apb(12'(4 * k), 1'b0, zero);
      chk(nm, rd, exp);
   endtask
   task automatic wr(input int k, input logic [31:0] d);
      apb(12'(4 * k), 1'b1, d);
   endtask
   task automatic pulse(input logic [28:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= '0;
   endtask
   function automatic logic [31:0] w1(input logic [17:0] a, input logic [7:0] s);
      return {10'h000, a[3:0], a[17:16], s, 8'h00};
   endfunction

   task automatic t_regs();
      rchk("straps", 6, 32'h0000_02aa);
      wr(6, 32'hffff_ffff);
      rchk("straps ro", 6, 32'h0000_02aa);
      wr(0, 32'hffff_ffff);
      rchk("unused", 0, zero);
      apb(12'h01c, 1'b0, zero);
      chk("unmapped", {31'h0000_0000, rerr}, 32'h0000_0001);
      chk("unmapped data", rd, zero);
      apb(12'h006, 1'b1, 32'hffff_ffff);
      chk("unaligned", {31'h0000_0000, rerr}, 32'h0000_0001);
      $display("regs done");
   endtask

   task automatic cm_hit(input logic [17:0] a, input logic [7:0] s, input logic dbl);
      cm_err_addr <= a;
      cm_syndrome <= s;
      cm_err_double <= dbl;
      pulse(29'h0000_0001);
   endtask
   task automatic t_cm();
      logic [17:0] a;
      a = 18'h2_a5c3;
      cm_hit(a, 8'h5a, 1'b1);
      rchk("cm flag", 0, 32'h0000_0008);
      rchk("cm synd", 1, w1(a, 8'h5a));
      rchk("cm addr mid", 4, {a[7:4], 28'h000_0000});
      rchk("cm dbl", 5, {8'h00, 1'b1, 15'h0000, a[15:8]});
      cm_hit(18'h1_0001, 8'h11, 1'b0);
      rchk("cm held", 1, w1(a, 8'h5a));
      wr(5, 32'h0000_0100);
      rchk("cm clr synd", 1, zero);
      rchk("cm clr dbl", 5, 32'h0000_0100);
      rchk("cm bit3 kept", 0, 32'h0000_0008);
      wr(5, zero);
      wr(0, 32'h0000_0008);
      rchk("cm w1c", 0, zero);
      cm_hit(a, 8'h01, 1'b0);
      rchk("cm single", 5, {24'h00_0000, a[15:8]});
      wr(5, 32'h0000_4100);
      wr(5, 32'h0000_4000);
      wr(0, 32'h0000_0008);
      cm_hit(a, 8'h80, 1'b1);
      rchk("par flag", 0, 32'h0000_0008);
      rchk("par no dbl", 5, {16'h0000, 8'h40, a[15:8]});
      rchk("par bits", 1, w1(a, 8'h80));
      wr(5, 32'h0000_0100);
      wr(5, zero);
      wr(0, 32'h0000_0008);
      $display("cm done");
   endtask

   task automatic t_lcm();
      lcm_err_double <= 1'b1;
      pulse(29'h0000_0002);
      rchk("lcm flag", 0, 32'h0000_0800);
      rchk("lcm dbl", 6, 32'h0000_02ba);
      wr(5, 32'h0001_0000);
      rchk("lcm clr", 6, 32'h0000_02aa);
      rchk("lcm kept", 0, 32'h0000_0800);
      wr(5, zero);
      wr(0, 32'h0000_0800);
      rchk("lcm w1c", 0, zero);
      lcm_err_double <= 1'b0;
      pulse(29'h0000_0002);
      rchk("lcm single", 6, 32'h0000_02aa);
      wr(5, 32'h0000_0800);
      lcm_err_double <= 1'b1;
      pulse(29'h0000_0002);
      rchk("lcm par", 0, 32'h0000_0800);
      rchk("lcm par dbl", 6, 32'h0000_02aa);
      wr(5, zero);
      wr(0, 32'h0000_0800);
      $display("lcm done");
   endtask

   task automatic t_events();
      for (int i = 0; i < 5; i++) begin
         ppu_opcode <= (i == 2) ? 6'h00 : (i == 3) ? 6'h3f : 6'h01;
         pulse(29'h0000_0004 << (i < 2 ? i : 2));
         rchk("unit err", 0, (i < 4) ? 32'h0000_0010 : zero);
         wr(0, 32'h0000_0010);
      end
      ce <= 1'b0;
      pulse(29'h0000_0020);
      ce <= 1'b1;
      rchk("ce hold", 0, zero);
      for (int j = 0; j < 2; j++) begin
         pulse(29'h0000_0020 << j);
         rchk("ichassis", 0, 32'h0000_0040 << j);
         wr(0, 32'h0000_00c0);
      end
      for (int i = 0; i < 10; i++) begin
         pulse(29'h0000_0080 << i);
         rchk("pp parity", 0, 32'h0000_4000 << i);
         wr(0, 32'h0000_4000 << i);
      end
      chan_check_disable <= 12'h0f2;
      cyc(6);
      pulse(29'h1ffe_0000);
      rchk("chan lo", 0, 32'h0d00_0000);
      rchk("chan hi", 1, 32'h0000_000f);
      wr(0, 32'hff00_0000);
      wr(1, 32'h0000_000f);
      chan_check_disable <= 12'h000;
      second_chassis_status <= 40'h80_0000_0000;
      cyc(6);
      rchk("second hi", 0, 32'h0000_0400);
      second_chassis_status <= 40'h00_0000_0001;
      cyc(6);
      rchk("second lo", 0, 32'h0000_0400);
      second_chassis_status <= '0;
      cyc(6);
      rchk("second off", 0, zero);
      $display("events done");
   endtask

   task automatic t_scan();
      for (int u = 3; u < 16; u += 12) begin
         wr(2, 32'(u) << 8);
         ppu_unit_err <= (80'h13 << (5 * u)) | (80'h0c << (5 * (u ^ 1)));
         cyc(4);
         chk("scan sel", {28'h000_0000, scanner_select}, 32'(u));
         rchk("unit bits", 4, 32'h0000_0130);
      end
      ppu_unit_err <= '0;
      wr(2, zero);
      $display("scan done");
   endtask

   task automatic t_power();
      int t0;
      int t36;
      int t37;
      mains_ok <= 1'b0;
      cyc(PF + 8);
      rchk("pf short", 1, 32'h0000_0010);
      mains_ok <= 1'b1;
      cyc(10);
      rchk("pf auto clr", 1, zero);
      t0 = now;
      t36 = 0;
      t37 = 0;
      mains_ok <= 1'b0;
      for (int i = 0; i < 200 && t37 == 0; i++) begin
         apb(12'h004, 1'b0, zero);
         if (rd[4] === 1'b1 && t36 == 0) t36 = now;
         if (rd[5] === 1'b1) t37 = now;
      end
      chk("pf delay", 32'(t36 - t0 >= PF), 32'h0000_0001);
      chk("shut delay", 32'(t37 - t0 >= SH), 32'h0000_0001);
      chk("pf leads", 32'(t37 - t36 >= SP), 32'h0000_0001);
      mains_ok <= 1'b1;
      cyc(10);
      rchk("pf held", 1, 32'h0000_0010);
      wr(1, 32'h0000_0010);
      rchk("pf w1c", 1, zero);
      env <= 3'h1;
      cyc(8);
      rchk("env shut", 1, 32'h0000_0020);
      env <= 3'h0;
      cyc(10);
      rchk("env auto clr", 1, zero);
      env <= 3'h2;
      cyc(8);
      env <= 3'h0;
      cyc(10);
      rchk("emerg held", 1, 32'h0000_0020);
      wr(1, 32'h0000_0020);
      rchk("emerg w1c", 1, zero);
      env <= 3'h4;
      cyc(8);
      rchk("ctl both", 1, 32'h0000_0030);
      env <= 3'h0;
      cyc(60);
      wr(1, 32'h0000_0030);
      rchk("ctl w1c", 1, zero);
      $display("power done");
   endtask

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, cm_err_double, lcm_err_double} = '0;
      paddr = '0;
      pwdata = '0;
      {cm_syndrome, cm_err_addr, ppu_opcode, ppu_unit_err} = '0;
      {second_chassis_status, chan_check_disable, env, ev} = '0;
      mains_ok = 1'b1;
      lcm_degrade = 4'ha;
      ppm_reconfig = 5'h15;
      {n_fail, samples_checked} = '0;
      cyc(3);
      presetn <= 1'b1;
      // pin synchronisers need a few cycles before the degrade bits read true; straps are caught directly
      cyc(4);
      t_regs();
      t_scan();
      t_cm();
      t_lcm();
      t_events();
      t_power();
      test_done();
   end
endmodule // tb_system_error_status_register
